// ==== common/accel_filter_orient_regs.vh ====
// Purpose: constants of the filter, range and orientation register bank
// Assumes: 8-bit register port, samples at 1024 counts per g
// Notes: offsets are register addresses on the device's register port
// Notes on behaviour
// [RULE_01] bit 4 puts high-pass samples on outputs
// [RULE_02] range 00=2g 01=4g 10=8g, reset 2g
// [RULE_03] pulse high-pass bypass bit, resets to 0
// [RULE_04] pulse low-pass enable bit, resets to 0
// [RULE_05] cut-off code picks corner per rate, mode
// [RULE_06] normal 800 Hz: 16, 8, 4, 2 Hz
// [RULE_07] change flag after first result when active
// [RULE_08] change flag on guard, facing or code change
// [RULE_09] status read clears flag and its interrupt
// [RULE_10] guard bit shows z-tilt lockout detected
// [RULE_11] code 00 up 01 down 10 right 11 left
// [RULE_12] facing bit 0 front, 1 back
// [RULE_13] orientation fields and flag reset to zero
// [RULE_14] fields keep updating while flag set
// [RULE_15] hold orientation when any axis exceeds 1.25g
// [RULE_16] config: bit 7 debounce mode, bit 6 enable
// [RULE_17] mode 0 decrements, mode 1 clears; default 1
// [RULE_18] enable bit gates detection, resets to 0
// [RULE_19] interrupt status follows enabled change flag
// [RULE_20] unused bits read zero, ignore writes
`ifndef ACCEL_FILTER_ORIENT_REGS_VH
`define ACCEL_FILTER_ORIENT_REGS_VH

`define OFS_OUTPUT_RANGE_CONFIG 8'h0e
`define OFS_HIGHPASS_CUTOFF_CONFIG 8'h0f
`define OFS_ORIENTATION_STATUS 8'h10
`define OFS_ORIENTATION_CONFIG 8'h11

`define POS_FILTERED_OUTPUT_SELECT 4
`define POS_FULL_SCALE_SELECT 0
`define POS_PULSE_HIGHPASS_BYPASS 5
`define POS_PULSE_LOWPASS_ENABLE 4
`define POS_CUTOFF_SELECT 0
`define POS_ORIENT_CHANGE_FLAG 7
`define POS_Z_TILT_GUARD 6
`define POS_PORTRAIT_LANDSCAPE_CODE 1
`define POS_BACK_FRONT_FLAG 0
`define POS_DEBOUNCE_MODE_SELECT 7
`define POS_ORIENT_DETECT_ENABLE 6

`define RST_OUTPUT_RANGE_CONFIG 8'h00
`define RST_HIGHPASS_CUTOFF_CONFIG 8'h00
`define RST_ORIENTATION_CONFIG 8'h80

`define RANGE_2G 2'h0
`define RANGE_4G 2'h1
`define RANGE_8G 2'h2

`define PL_PORTRAIT_UP 2'h0
`define PL_PORTRAIT_DOWN 2'h1
`define PL_LANDSCAPE_RIGHT 2'h2
`define PL_LANDSCAPE_LEFT 2'h3

`define OS_NORMAL 2'h0
`define OS_LOW_NOISE_LOW_POWER 2'h1
`define OS_HIGH_RESOLUTION 2'h2
`define OS_LOW_POWER 2'h3

`define COUNTS_PER_G 1024
`define LOCK_LIMIT_MILLI_G 1250
`define HP_SHIFT_BIAS 5'h03

`endif

// ==== hdl/hp_axis.v ====
// Purpose: one axis of the first-order high-pass filter
// Assumes: shift sets the corner, larger shift means lower corner
// Notes: output is combinational from the present sample and state
`timescale 1ns/1ps
module hp_axis (
    // clock and reset
    input wire i_sys_clk,
    input wire i_arst_n,
    // control
    input wire i_step,
    input wire i_clear,
    input wire [3:0] i_shift,
    // data
    input wire signed [13:0] i_sample,
    output wire signed [14:0] o_hp
);
    reg signed [21:0] lp_q;
    wire signed [21:0] x_ext;
    wire signed [22:0] diff;
    wire signed [22:0] step;

    assign x_ext = {i_sample, 8'h00};
    assign diff = {x_ext[21], x_ext} - {lp_q[21], lp_q};
    assign step = diff >>> i_shift;
    // the low-pass track holds eight fraction bits so slow corners settle
    assign o_hp = {i_sample[13], i_sample} - {lp_q[21], lp_q[21:8]};

    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lp_q <= 22'h000000;
        end else if (i_clear) begin
            // seeding with the sample avoids a start-up step at the output
            lp_q <= x_ext;
        end else if (i_step) begin
            lp_q <= lp_q + step[21:0];
        end
    end
endmodule

// ==== hdl/accel_filter_orient_regs.v ====
// Purpose: range, high-pass and orientation registers with their logic
// Assumes: register port from the serial front end, one access a cycle
// Notes: samples are signed, 1024 counts per g, valid for one cycle
`timescale 1ns/1ps
`include "accel_filter_orient_regs.vh"
module accel_filter_orient_regs (
    // clock and reset
    input wire i_sys_clk,
    input wire i_arst_n,
    // register port
    input wire [7:0] i_reg_addr,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_wdata,
    output reg [7:0] o_reg_rdata,
    // sample stream and device state
    input wire i_sample_valid,
    input wire signed [13:0] i_x,
    input wire signed [13:0] i_y,
    input wire signed [13:0] i_z,
    input wire i_active,
    input wire [2:0] i_odr_code,
    input wire [1:0] i_os_mode,
    input wire [7:0] i_debounce_count,
    input wire i_orient_irq_en,
    // output data and settings
    output reg o_data_valid,
    output reg [11:0] o_x_data,
    output reg [11:0] o_y_data,
    output reg [11:0] o_z_data,
    output reg [1:0] o_full_scale_select,
    output reg o_pulse_highpass_bypass,
    output reg o_pulse_lowpass_enable,
    output reg [3:0] o_hp_corner_oct,
    output reg o_orient_irq_status
);
    localparam integer LOCK_FULL =
        (`LOCK_LIMIT_MILLI_G * `COUNTS_PER_G) / 1000;
    localparam [13:0] LOCK_CNT = LOCK_FULL[13:0];

    reg filtered_output_select_q;
    reg [1:0] cutoff_q;
    reg debounce_mode_select_q;
    reg orient_detect_enable_q;
    reg orient_change_flag_q;
    reg z_tilt_guard_q;
    reg [1:0] portrait_landscape_code_q;
    reg back_front_flag_q;
    reg first_pend_q;
    reg active_q;
    reg enable_q;
    reg [7:0] dbc_q;

    wire wr_range = i_reg_wr && i_reg_addr == `OFS_OUTPUT_RANGE_CONFIG;
    wire wr_cutoff = i_reg_wr && i_reg_addr == `OFS_HIGHPASS_CUTOFF_CONFIG;
    wire wr_cfg = i_reg_wr && i_reg_addr == `OFS_ORIENTATION_CONFIG;
    wire rd_status = i_reg_rd && i_reg_addr == `OFS_ORIENTATION_STATUS;

    // corner in octaves below 16 Hz, set by rate, mode and code
    function [3:0] corner_oct;
        input [2:0] odr;
        input [1:0] os;
        input [1:0] sel;
        reg [3:0] base;
        begin
            base = 4'h0;
            case (os)
                `OS_NORMAL: begin
                    case (odr)
                        3'h0, 3'h1: base = 4'h0;
                        3'h2: base = 4'h1;
                        3'h3: base = 4'h2;
                        default: base = 4'h3;
                    endcase
                end
                `OS_LOW_NOISE_LOW_POWER: begin
                    case (odr)
                        3'h0, 3'h1: base = 4'h0;
                        3'h2: base = 4'h1;
                        3'h3: base = 4'h2;
                        3'h4: base = 4'h3;
                        default: base = 4'h5;
                    endcase
                end
                `OS_HIGH_RESOLUTION: base = 4'h0;
                default: begin
                    case (odr)
                        3'h0, 3'h1, 3'h2, 3'h3, 3'h4: base = {1'b0, odr};
                        default: base = 4'h6;
                    endcase
                end
            endcase
            corner_oct = base + {2'h0, sel};
        end
    endfunction

    // octaves below 800 Hz of the output data rate
    function [3:0] odr_oct;
        input [2:0] odr;
        begin
            case (odr)
                3'h0, 3'h1, 3'h2, 3'h3, 3'h4: odr_oct = {1'b0, odr};
                3'h5: odr_oct = 4'h6;
                3'h6: odr_oct = 4'h7;
                default: odr_oct = 4'h9;
            endcase
        end
    endfunction

    // scale a 1024 count/g value into the 12-bit output, saturating
    function [11:0] scale12;
        input signed [14:0] a;
        input [1:0] rng;
        reg signed [14:0] s;
        begin
            case (rng)
                `RANGE_4G: s = a >>> 1;
                `RANGE_8G: s = a >>> 2;
                default: s = a;
            endcase
            if (s > 15'sd2047)
                scale12 = 12'h7ff;
            else if (s < -15'sd2048)
                scale12 = 12'h800;
            else
                scale12 = s[11:0];
        end
    endfunction

    function [13:0] mag;
        input signed [13:0] a;
        begin
            mag = a[13] ? (~a + 14'h0001) : a;
        end
    endfunction

    wire [3:0] corner_w =
        corner_oct(i_odr_code, i_os_mode, cutoff_q); // RULE_05
    wire [3:0] odr_w = odr_oct(i_odr_code);
    wire [4:0] shift_raw = {1'b0, corner_w} + `HP_SHIFT_BIAS - {1'b0, odr_w};
    // a negative or zero shift means the corner is above the usable band
    wire [3:0] hp_shift = (shift_raw[4] || shift_raw == 5'h00) ? 4'h1
        : (shift_raw > 5'h0f ? 4'hf : shift_raw[3:0]);
    wire signed [14:0] hp_x;
    wire signed [14:0] hp_y;
    wire signed [14:0] hp_z;

    hp_axis u_hp_x (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_step(i_sample_valid),
        .i_clear(~i_active),
        .i_shift(hp_shift),
        .i_sample(i_x),
        .o_hp(hp_x)
    );
    hp_axis u_hp_y (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_step(i_sample_valid),
        .i_clear(~i_active),
        .i_shift(hp_shift),
        .i_sample(i_y),
        .o_hp(hp_y)
    );
    hp_axis u_hp_z (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_step(i_sample_valid),
        .i_clear(~i_active),
        .i_shift(hp_shift),
        .i_sample(i_z),
        .o_hp(hp_z)
    );

    // orientation candidate from the present sample
    wire [13:0] ax = mag(i_x);
    wire [13:0] ay = mag(i_y);
    wire [13:0] az = mag(i_z);
    wire over_limit = ax > LOCK_CNT || ay > LOCK_CNT || az > LOCK_CNT;
    wire [13:0] xy_max = (ax > ay) ? ax : ay;
    // about tan(29 deg) of the z magnitude
    wire [13:0] tilt_lim = {1'b0, az[13:1]} + {4'h0, az[13:4]};
    wire guard_c = xy_max < tilt_lim;
    reg [1:0] pl_c;
    always @* begin
        if (guard_c)
            pl_c = portrait_landscape_code_q;
        else if (ay >= ax)
            pl_c = i_y[13] ? `PL_PORTRAIT_DOWN : `PL_PORTRAIT_UP; // RULE_11
        else
            pl_c = i_x[13] ? `PL_LANDSCAPE_LEFT : `PL_LANDSCAPE_RIGHT;
    end
    wire bf_c = i_z[13]; // RULE_12
    wire [3:0] cand = {guard_c, pl_c, bf_c};
    wire [3:0] cur = {z_tilt_guard_q, portrait_landscape_code_q,
        back_front_flag_q};
    wire run = i_sample_valid && i_active && orient_detect_enable_q; // RULE_18
    wire first_now = run && !over_limit && first_pend_q;
    wire commit = run && !over_limit && !first_pend_q && cand != cur
        && dbc_q >= i_debounce_count;
    wire set_flag = first_now || commit; // RULE_07 RULE_08
    wire start = (i_active && !active_q)
        || (orient_detect_enable_q && !enable_q);

    // configuration registers
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            filtered_output_select_q <= 1'b0;
            o_full_scale_select <= `RANGE_2G; // RULE_02
            o_pulse_highpass_bypass <= 1'b0; // RULE_03
            o_pulse_lowpass_enable <= 1'b0; // RULE_04
            cutoff_q <= 2'h0; // RULE_05
            debounce_mode_select_q <= 1'b1; // RULE_17
            orient_detect_enable_q <= 1'b0; // RULE_18
        end else begin
            if (wr_range) begin
                filtered_output_select_q <=
                    i_reg_wdata[`POS_FILTERED_OUTPUT_SELECT];
                o_full_scale_select <=
                    i_reg_wdata[`POS_FULL_SCALE_SELECT +: 2];
            end
            if (wr_cutoff) begin
                o_pulse_highpass_bypass <=
                    i_reg_wdata[`POS_PULSE_HIGHPASS_BYPASS]; // RULE_03
                o_pulse_lowpass_enable <=
                    i_reg_wdata[`POS_PULSE_LOWPASS_ENABLE]; // RULE_04
                cutoff_q <= i_reg_wdata[`POS_CUTOFF_SELECT +: 2];
            end
            if (wr_cfg) begin
                debounce_mode_select_q <=
                    i_reg_wdata[`POS_DEBOUNCE_MODE_SELECT]; // RULE_16
                orient_detect_enable_q <=
                    i_reg_wdata[`POS_ORIENT_DETECT_ENABLE]; // RULE_16
            end
        end
    end

    // output data path, one cycle after the sample
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_data_valid <= 1'b0;
            o_x_data <= 12'h000;
            o_y_data <= 12'h000;
            o_z_data <= 12'h000;
            o_hp_corner_oct <= 4'h0;
        end else begin
            o_data_valid <= i_sample_valid;
            o_hp_corner_oct <= corner_w; // RULE_06
            if (i_sample_valid) begin
                if (filtered_output_select_q) begin
                    o_x_data <= scale12(hp_x, o_full_scale_select); // RULE_01
                    o_y_data <= scale12(hp_y, o_full_scale_select);
                    o_z_data <= scale12(hp_z, o_full_scale_select);
                end else begin
                    o_x_data <= scale12({i_x[13], i_x}, o_full_scale_select);
                    o_y_data <= scale12({i_y[13], i_y}, o_full_scale_select);
                    o_z_data <= scale12({i_z[13], i_z}, o_full_scale_select);
                end
            end
        end
    end

    // orientation tracking and debounce
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            z_tilt_guard_q <= 1'b0; // RULE_13
            portrait_landscape_code_q <= `PL_PORTRAIT_UP;
            back_front_flag_q <= 1'b0;
            first_pend_q <= 1'b0;
            active_q <= 1'b0;
            enable_q <= 1'b0;
            dbc_q <= 8'h00;
        end else begin
            active_q <= i_active;
            enable_q <= orient_detect_enable_q;
            if (!i_active) begin
                dbc_q <= 8'h00;
            end
            if (start) begin
                first_pend_q <= 1'b1;
                dbc_q <= 8'h00;
            end else if (run && !over_limit) begin // RULE_15
                if (first_pend_q || commit) begin
                    // fields follow the live result even with the flag set
                    z_tilt_guard_q <= cand[3]; // RULE_10 RULE_14
                    portrait_landscape_code_q <= cand[2:1];
                    back_front_flag_q <= cand[0];
                    first_pend_q <= 1'b0;
                    dbc_q <= 8'h00;
                end else if (cand != cur) begin
                    dbc_q <= dbc_q + 8'h01;
                end else if (debounce_mode_select_q) begin
                    dbc_q <= 8'h00; // RULE_17
                end else if (dbc_q != 8'h00) begin
                    dbc_q <= dbc_q - 8'h01; // RULE_17
                end
            end
        end
    end

    // change flag and interrupt status; a new change beats the read
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            orient_change_flag_q <= 1'b0; // RULE_13
            o_orient_irq_status <= 1'b0;
        end else begin
            orient_change_flag_q <= set_flag
                || (orient_change_flag_q && !rd_status); // RULE_09
            o_orient_irq_status <= i_orient_irq_en && (set_flag
                || (orient_change_flag_q && !rd_status)); // RULE_19
        end
    end

    // read data, unused and unmapped bits return zero
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                `OFS_OUTPUT_RANGE_CONFIG:
                    o_reg_rdata <= {3'h0, filtered_output_select_q, 2'h0,
                        o_full_scale_select}; // RULE_20
                `OFS_HIGHPASS_CUTOFF_CONFIG:
                    o_reg_rdata <= {2'h0, o_pulse_highpass_bypass,
                        o_pulse_lowpass_enable, 2'h0, cutoff_q};
                `OFS_ORIENTATION_STATUS:
                    o_reg_rdata <= {orient_change_flag_q, z_tilt_guard_q,
                        3'h0, portrait_landscape_code_q, back_front_flag_q};
                `OFS_ORIENTATION_CONFIG:
                    o_reg_rdata <= {debounce_mode_select_q,
                        orient_detect_enable_q, 6'h00}; // RULE_16
                default:
                    o_reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule

// ==== testbench/accel_filter_orient_regs_sva.sv ====
// Purpose: port checks of the range, filter and orientation bank
// Assumes: register strobes are one-cycle pulses
// Notes: irq is registered, so its clear is checked two edges on
`timescale 1ns/1ps
module regs_checker (
    // clock and reset
    input logic i_sys_clk,
    input logic i_arst_n,
    // register port
    input logic [7:0] i_reg_addr,
    input logic i_reg_wr,
    input logic i_reg_rd,
    input logic [7:0] i_reg_wdata,
    input logic [7:0] o_reg_rdata,
    // stream and state
    input logic i_sample_valid,
    input logic [2:0] i_odr_code,
    input logic [1:0] i_os_mode,
    input logic i_orient_irq_en,
    // outputs
    input logic o_data_valid,
    input logic [1:0] o_full_scale_select,
    input logic o_pulse_highpass_bypass,
    input logic o_pulse_lowpass_enable,
    input logic [3:0] o_hp_corner_oct,
    input logic o_orient_irq_status
);
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_arst_n);
    sequence s_cut_fast;
        i_reg_wr && i_reg_addr == 8'h0f && i_os_mode == 2'h0
            && i_odr_code == 3'h0;
    endsequence
    sequence s_settle;
        (!i_reg_wr && i_os_mode == 2'h0 && i_odr_code == 3'h0) [*2];
    endsequence
    sequence s_status_read;
        i_reg_rd && i_reg_addr == 8'h10 && !i_sample_valid
            ##1 !i_sample_valid;
    endsequence

    AST_DATA_VALID: assert property (i_sample_valid
        |=> o_data_valid)
        else $error("no data valid after sample");
    AST_DATA_PULSE: assert property (!i_sample_valid
        |=> !o_data_valid)
        else $error("data valid without sample");
    AST_RANGE_WRITE: assert property (i_reg_wr
        && i_reg_addr == 8'h0e
        |=> o_full_scale_select == $past(i_reg_wdata[1:0]))
        else $error("range field not taken from write");
    AST_RANGE_HOLD: assert property (!(i_reg_wr
        && i_reg_addr == 8'h0e) |=> $stable(o_full_scale_select))
        else $error("range field moved without write");
    AST_PULSE_BITS: assert property (i_reg_wr
        && i_reg_addr == 8'h0f
        |=> {o_pulse_highpass_bypass, o_pulse_lowpass_enable}
            == $past(i_reg_wdata[5:4]))
        else $error("pulse path bits not taken from write");
    AST_CORNER_FAST: assert property (s_cut_fast ##1 s_settle
        |-> o_hp_corner_oct == {2'h0, $past(i_reg_wdata[1:0], 2)})
        else $error("corner wrong at fastest normal rate");
    AST_UNUSED_ZERO: assert property (i_reg_rd
        && i_reg_addr == 8'h0e
        |=> o_reg_rdata[7:5] == 3'h0 && o_reg_rdata[3:2] == 2'h0)
        else $error("unused range bits read nonzero");
    AST_IRQ_CLEAR: assert property (s_status_read
        |=> !o_orient_irq_status)
        else $error("irq status survived status read");
    AST_IRQ_GATE: assert property (!i_orient_irq_en
        |=> !o_orient_irq_status)
        else $error("irq status while disabled");
endmodule
bind accel_filter_orient_regs regs_checker chk (.i_sys_clk, .i_arst_n,
    .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata,
    .i_sample_valid, .i_odr_code, .i_os_mode, .i_orient_irq_en,
    .o_data_valid, .o_full_scale_select, .o_pulse_highpass_bypass,
    .o_pulse_lowpass_enable, .o_hp_corner_oct, .o_orient_irq_status);

// ==== testbench/host_model.sv ====
// Purpose: host side of the register port, one access per call
// Assumes: access taken at one rising edge, read data holds after
// Notes: released address and data are inverted so stale values show
`timescale 1ns/1ps
module host_model (
    // clock
    input wire i_sys_clk,
    // register port toward the bank
    output logic [7:0] o_addr = 8'h00,
    output logic o_wr = 1'b0,
    output logic o_rd = 1'b0,
    output logic [7:0] o_wdata = 8'h00,
    input wire [7:0] i_rdata
);
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_sys_clk);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_sys_clk);
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_sys_clk);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_sys_clk);
        o_rd = 1'b0;
        o_addr = ~a;
        @(negedge i_sys_clk);
        d = i_rdata;
    endtask
endmodule

// ==== testbench/testbench.sv ====
// Purpose: register and sample sequences against the bank
// Assumes: debounce count zero, so changes commit at once, except in
// the debounce mode rows
// Notes: expected status bytes are worked out by hand per row
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sv = 1'b0;
    logic act = 1'b0;
    logic irq_en = 1'b0;
    logic signed [13:0] ax = 14'sd0, ay = 14'sd0, az = 14'sd0;
    logic [2:0] odr = 3'h0;
    logic [1:0] osm = 2'h0;
    logic [7:0] a, wd, rdat;
    logic wr, rd, dv, byp, lpe, irq;
    logic [11:0] xd, yd, zd;
    logic [1:0] rsel;
    logic [3:0] oct;
    logic [7:0] dbc = 8'h00;
    logic [11:0] ex, ez;
    int fails = 0;
    int compares = 0;
    logic [10:0] cut [0:8] = '{11'h000, 11'h011, 11'h022, 11'h033,
        11'h201, 11'h1c1, 11'h791, 11'h545, 11'h736};
    logic signed [13:0] ox [0:5] = '{0, 0, 1000, -1000, 0, 1281};
    logic signed [13:0] oy [0:5] = '{1000, -1000, 0, 0, 0, 0};
    logic signed [13:0] oz [0:5] = '{0, 0, 0, 0, -1000, 0};
    logic [7:0] oe [0:5] = '{8'h80, 8'h82, 8'h84, 8'h86, 8'hc7, 8'h47};

    initial begin
        forever #4 clk = ~clk;
    end
    host_model h (.i_sys_clk(clk), .o_addr(a), .o_wr(wr), .o_rd(rd),
        .o_wdata(wd), .i_rdata(rdat));
    accel_filter_orient_regs dut (.i_sys_clk(clk), .i_arst_n(rst_n),
        .i_reg_addr(a), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd),
        .o_reg_rdata(rdat), .i_sample_valid(sv), .i_x(ax), .i_y(ay),
        .i_z(az), .i_active(act), .i_odr_code(odr), .i_os_mode(osm),
        .i_debounce_count(dbc), .i_orient_irq_en(irq_en),
        .o_data_valid(dv), .o_x_data(xd), .o_y_data(yd), .o_z_data(zd),
        .o_full_scale_select(rsel), .o_pulse_highpass_bypass(byp),
        .o_pulse_lowpass_enable(lpe), .o_hp_corner_oct(oct),
        .o_orient_irq_status(irq));

    task automatic chk(input string n, input logic [11:0] e,
                       input logic [11:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
        logic [7:0] d;
        h.rd_reg(ad, d);
        chk($sformatf("reg %h", ad), {4'h0, e}, {4'h0, d});
    endtask
    task automatic smp(input logic signed [13:0] x, y, z);
        @(negedge clk);
        ax = x;
        ay = y;
        az = z;
        sv = 1'b1;
        @(negedge clk);
        sv = 1'b0;
    endtask
    task automatic wrap_up;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #400000;
        fails++;
        $display("MISMATCH watchdog expected end seen hang");
        wrap_up();
    end

    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        rchk(8'h0e, 8'h00);
        rchk(8'h0f, 8'h00);
        rchk(8'h10, 8'h00);
        rchk(8'h11, 8'h80);
        rchk(8'h12, 8'h00);
        h.wr_reg(8'h0e, 8'hff);
        rchk(8'h0e, 8'h13);
        h.wr_reg(8'h0f, 8'hff);
        rchk(8'h0f, 8'h33);
        chk("bypass", 12'h1, {11'h0, byp});
        chk("lowpass", 12'h1, {11'h0, lpe});
        h.wr_reg(8'h0f, 8'h00);
        chk("bypass", 12'h0, {11'h0, byp});
        chk("lowpass", 12'h0, {11'h0, lpe});
        h.wr_reg(8'h10, 8'hff);
        rchk(8'h10, 8'h00);
        h.wr_reg(8'h11, 8'hff);
        rchk(8'h11, 8'hc0);
        h.wr_reg(8'h11, 8'h00);
        // code 3 is reserved and must scale like 2g; z saturates at 2g
        for (int i = 0; i < 4; i++) begin
            h.wr_reg(8'h0e, i[7:0]);
            smp(14'sd1000, -14'sd1000, 14'sd3000);
            ex = (i == 3) ? 12'd1000 : 12'd1000 >> i;
            ez = (i == 1) ? 12'd1500 : (i == 2) ? 12'd750 : 12'h7ff;
            chk("valid", 12'h1, {11'h0, dv});
            chk("range", {10'h0, i[1:0]}, {10'h0, rsel});
            chk("x range", ex, xd);
            chk("y range", -ex, yd);
            chk("z range", ez, zd);
        end
        h.wr_reg(8'h0e, 8'h10);
        smp(14'sd1000, 14'sd0, 14'sd0);
        act = 1'b1;
        smp(14'sd1000, 14'sd0, 14'sd0);
        chk("x highpass", 12'h000, xd);
        h.wr_reg(8'h0e, 8'h00);
        smp(14'sd1000, 14'sd0, 14'sd0);
        chk("x raw", 12'd1000, xd);
        for (int i = 0; i < 9; i++) begin
            odr = cut[i][10:8];
            osm = cut[i][7:6];
            h.wr_reg(8'h0f, {6'h0, cut[i][5:4]});
            repeat (2) @(negedge clk);
            chk("corner", {8'h0, cut[i][3:0]}, {8'h0, oct});
        end
        irq_en = 1'b1;
        h.wr_reg(8'h11, 8'hc0);
        for (int i = 0; i < 6; i++) begin
            smp(ox[i], oy[i], oz[i]);
            @(negedge clk);
            if (i == 0) chk("irq", 12'h1, {11'h0, irq});
            rchk(8'h10, oe[i]);
            if (i == 0) chk("irq", 12'h0, {11'h0, irq});
        end
        // last row was over the limit, so the held position must show
        chk("hold", 12'h047, {4'h0, rdat});
        smp(14'sd0, 14'sd1000, 14'sd0);
        smp(14'sd0, -14'sd1000, 14'sd0);
        rchk(8'h10, 8'h82);
        rchk(8'h10, 8'h02);
        h.wr_reg(8'h11, 8'h80);
        smp(14'sd1000, 14'sd0, 14'sd0);
        rchk(8'h10, 8'h02);
        act = 1'b0;
        h.wr_reg(8'h11, 8'hc0);
        act = 1'b1;
        smp(14'sd0, -14'sd1000, 14'sd0);
        rchk(8'h10, 8'h82);
        // two differing, one equal, two differing with count 2: only the
        // decrementing mode reaches the count and commits
        dbc = 8'h02;
        for (int m = 0; m < 2; m++) begin
            h.wr_reg(8'h11, m ? 8'h40 : 8'hc0);
            for (int j = 0; j < 6; j++) begin
                smp(14'sd0, (j % 3 == 2) ? -14'sd1000 : 14'sd1000, 14'sd0);
                if (j == 4) rchk(8'h10, m ? 8'h80 : 8'h02);
            end
        end
        wrap_up();
    end
endmodule
